// ===== dmt_pkg.sv
// constants and register map for the dma missed-event error tracker
// assumes a simple strobe register port with 32-bit data
// Contract
// - second trigger while previous still pending sets channel missed flag
// - manual, chained and hardware triggers judged separately per channel
// - trigger hitting null entry or serviced null request sets dma flag
// - any dma flag set raises error interrupt if all errors were clear
// - channels 0 to 31 reported in low flag register, bit n
// - channels 32 to 63 reported in high flag register, bit n-32
// - a set flag holds until software clears it
// - clear write clears flags where written bit is 1 only
// - no further error interrupt while any error flag stays set
// - two quick triggers without service set quick channel flag
// - quick trigger hitting null entry or null request sets quick flag
// - any quick flag set raises error interrupt if all errors were clear
// - quick flags in bits 3-0, upper bits read as zero
// - flag registers read-only, reset to zero, writes ignored
// - clear registers write-only, reset zero, read as zero
// - quick flags cleared by write-one to separate clear register
package dmt_pkg;
  localparam int DMT_AW = 4;
  localparam int DMT_DW = 32;
  localparam int DMT_NCH = 64;
  localparam int DMT_NQ = 4;
  localparam int DMT_NSRC = 3;
  // register indices; byte address is four times the index
  localparam logic [DMT_AW-1:0] DMT_FLAGS_LOW = 4'h0;
  localparam logic [DMT_AW-1:0] DMT_FLAGS_HIGH = 4'h1;
  localparam logic [DMT_AW-1:0] DMT_CLEAR_LOW = 4'h2;
  localparam logic [DMT_AW-1:0] DMT_CLEAR_HIGH = 4'h3;
  localparam logic [DMT_AW-1:0] DMT_QUICK_FLAGS = 4'h4;
  localparam logic [DMT_AW-1:0] DMT_QUICK_CLEAR = 4'h5;
  localparam logic [DMT_DW-1:0] DMT_RST = 32'h0000_0000;
  localparam logic [DMT_DW-1:0] DMT_ZERO = 32'h0000_0000;
  // trigger source index
  localparam int DMT_SRC_MAN = 0;
  localparam int DMT_SRC_CHN = 1;
  localparam int DMT_SRC_HW = 2;
endpackage : dmt_pkg

// ===== dmt_miss_cell.sv
// per-channel miss detector for one channel
// assumes trigger and service inputs are synchronous single-cycle pulses
`timescale 1ns/1ps
module dmt_miss_cell
  import dmt_pkg::*;
(
  input wire logic i_sys_clk, // system clock
  input wire logic i_resetn, // async reset, active low
  input wire logic [DMT_NSRC-1:0] i_trig, // trigger per source
  input wire logic [DMT_NSRC-1:0] i_serv, // service per source
  input wire logic i_null, // null entry or null request
  input wire logic i_clr, // software clear
  output logic o_flag // missed flag
);
  logic [DMT_NSRC-1:0] pend;
  wire [DMT_NSRC-1:0] miss_src = i_trig & pend & ~i_serv;
  wire set_miss = (|miss_src) | i_null;
  wire next_flag = set_miss | (o_flag & ~i_clr);

  // pending per trigger type; service and new trigger in one cycle keep it
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend <= '0;
      o_flag <= 1'b0;
    end else begin
      pend <= i_trig | (pend & ~i_serv);
      o_flag <= next_flag;
    end
  end

  chk_miss_sets: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    set_miss |=> o_flag) else $error("miss not flagged");
  chk_flag_holds: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_flag && !i_clr |=> o_flag) else $error("flag dropped");
endmodule : dmt_miss_cell

// ===== dmt_tracker.sv
// missed-event flag registers, clears and error interrupt edge logic
// assumes one-cycle strobes from a master that never waits
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dmt_tracker
  import dmt_pkg::*;
#(
  parameter int NCH = DMT_NCH,
  parameter int NQ = DMT_NQ
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_resetn, // async reset, active low
  input wire logic [DMT_AW-1:0] i_addr, // register index
  input wire logic [DMT_DW-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [DMT_DW-1:0] o_rdata, // read data, cycle after i_rd
  input wire logic [NCH-1:0] i_manual_trigger_set, // manual triggers
  input wire logic [NCH-1:0] i_chain_trigger_flags, // chained triggers
  input wire logic [NCH-1:0] i_hw_event_latch, // hardware triggers
  input wire logic [NCH-1:0] i_dma_serv_man, // manual trigger serviced
  input wire logic [NCH-1:0] i_dma_serv_chn, // chained trigger serviced
  input wire logic [NCH-1:0] i_dma_serv_hw, // hw trigger serviced
  input wire logic [NCH-1:0] i_dma_null, // null entry or null request
  input wire logic [NQ-1:0] i_quick_trig, // quick channel triggers
  input wire logic [NQ-1:0] i_quick_serv, // quick trigger serviced
  input wire logic [NQ-1:0] i_quick_null, // quick null entry or request
  input wire logic i_other_err, // any other error register bit set
  output logic o_err_pulse, // one-cycle error interrupt
  output logic o_any_err // combined error level
);
  logic [NCH-1:0] dma_flag;
  logic [NQ-1:0] quick_flag;
  logic err_seen;

  // write decode: clear pulses only, nothing is stored
  wire wr_clr_lo = i_wr && (i_addr == DMT_CLEAR_LOW);
  wire wr_clr_hi = i_wr && (i_addr == DMT_CLEAR_HIGH);
  wire wr_clr_q = i_wr && (i_addr == DMT_QUICK_CLEAR);
  wire [NCH-1:0] dma_clr = {i_wdata & {DMT_DW{wr_clr_hi}},
                            i_wdata & {DMT_DW{wr_clr_lo}}};
  wire [NQ-1:0] quick_clr = i_wdata[NQ-1:0] & {NQ{wr_clr_q}};

  // one cell per dma channel
  genvar g;
  for (g = 0; g < NCH; g++) begin : g_dma
    dmt_miss_cell u_cell (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_trig({i_hw_event_latch[g], i_chain_trigger_flags[g],
               i_manual_trigger_set[g]}),
      .i_serv({i_dma_serv_hw[g], i_dma_serv_chn[g], i_dma_serv_man[g]}),
      .i_null(i_dma_null[g]),
      .i_clr(dma_clr[g]),
      .o_flag(dma_flag[g])
    );
  end

  // quick channels have a single trigger source
  for (g = 0; g < NQ; g++) begin : g_quick
    dmt_miss_cell u_cell (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_trig({{(DMT_NSRC-1){1'b0}}, i_quick_trig[g]}),
      .i_serv({{(DMT_NSRC-1){1'b0}}, i_quick_serv[g]}),
      .i_null(i_quick_null[g]),
      .i_clr(quick_clr[g]),
      .o_flag(quick_flag[g])
    );
  end

  // read mux; clear registers and unmapped indices read zero
  logic [DMT_DW-1:0] rd_mux;
  always_comb begin
    rd_mux = DMT_ZERO;
    unique case (i_addr)
      DMT_FLAGS_LOW: rd_mux = dma_flag[DMT_DW-1:0];
      DMT_FLAGS_HIGH: rd_mux = dma_flag[2*DMT_DW-1:DMT_DW];
      DMT_QUICK_FLAGS: rd_mux = {{(DMT_DW-NQ){1'b0}}, quick_flag};
      default: rd_mux = DMT_ZERO;
    endcase
  end

  wire any_err = (|dma_flag) | (|quick_flag) | i_other_err;
  // interrupt only on the all-clear to flagged edge of the combined errors
  wire next_pulse = any_err && !err_seen;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= DMT_RST;
      err_seen <= 1'b0;
      o_err_pulse <= 1'b0;
      o_any_err <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_mux : DMT_ZERO;
      err_seen <= any_err;
      o_err_pulse <= next_pulse;
      o_any_err <= any_err;
    end
  end

  chk_no_rearm: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_err_pulse |=> !o_err_pulse) else $error("double interrupt");
  chk_irq_edge: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(|dma_flag) && !$past(|quick_flag) && !$past(i_other_err)
    |=> o_err_pulse) else $error("missing interrupt");
  chk_quick_irq: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(|quick_flag) && !$past(|dma_flag) && !$past(i_other_err)
    |=> o_err_pulse) else $error("missing quick interrupt");
  chk_held_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $past(any_err) && any_err |=> !o_err_pulse)
    else $error("interrupt while errors held");
  chk_clear_low: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    wr_clr_lo && i_wdata[0] && !i_dma_null[0] && !i_manual_trigger_set[0]
    && !i_chain_trigger_flags[0] && !i_hw_event_latch[0] |=> !dma_flag[0])
    else $error("clear ignored");
  chk_set_wins: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_dma_null[0] && dma_clr[0] |=> dma_flag[0])
    else $error("set lost to clear");
  chk_ro_write: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_wr && i_addr == DMT_FLAGS_LOW && dma_flag[0] |=> dma_flag[0])
    else $error("write altered flag");
  chk_quick_rsvd: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_rd && i_addr == DMT_QUICK_FLAGS |=> o_rdata[DMT_DW-1:NQ] == '0)
    else $error("reserved bits nonzero");
  chk_read_high: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_rd && i_addr == DMT_FLAGS_HIGH
    |=> o_rdata == $past(dma_flag[2*DMT_DW-1:DMT_DW]))
    else $error("high read wrong");
  chk_read_low: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_rd && i_addr == DMT_FLAGS_LOW
    |=> o_rdata == $past(dma_flag[DMT_DW-1:0]))
    else $error("low read wrong");
  chk_clr_reads0: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_rd && i_addr == DMT_CLEAR_LOW |=> o_rdata == '0)
    else $error("clear register readable");
endmodule : dmt_tracker

// ===== tb_top.sv
// testbench for the missed-event tracker: register reads, writes and triggers
// assumes the strobe register port and single-cycle trigger pulses
`timescale 1ns/1ps
module tb_top;
  import dmt_pkg::*;
  logic i_sys_clk, i_resetn, i_wr, i_rd, i_other_err, o_err_pulse, o_any_err;
  logic [DMT_AW-1:0] i_addr;
  logic [DMT_DW-1:0] i_wdata, o_rdata;
  logic [DMT_NCH-1:0] man, chn, hw, s_man, s_chn, s_hw, dnull;
  logic [DMT_NQ-1:0] q_trig, q_serv, q_null;
  int error_cnt = 0, compares = 0, pulses = 0;
  dmt_tracker dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_manual_trigger_set(man),
    .i_chain_trigger_flags(chn), .i_hw_event_latch(hw),
    .i_dma_serv_man(s_man), .i_dma_serv_chn(s_chn), .i_dma_serv_hw(s_hw),
    .i_dma_null(dnull), .i_quick_trig(q_trig), .i_quick_serv(q_serv),
    .i_quick_null(q_null), .i_other_err(i_other_err),
    .o_err_pulse(o_err_pulse), .o_any_err(o_any_err));
  // clock at 100 MHz
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // interrupt pulses counted so that repeats cannot hide
  always @(posedge i_sys_clk) if (o_err_pulse === 1'b1) pulses++;
  task automatic tally_and_finish;
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // raise one pulse bit; k picks the source, tick drops all of them
  task automatic arm(int k, int ch);
    case (k)
      0: man[ch] <= 1'b1;
      1: chn[ch] <= 1'b1;
      2: hw[ch] <= 1'b1;
      3: s_man[ch] <= 1'b1;
      4: s_chn[ch] <= 1'b1;
      5: s_hw[ch] <= 1'b1;
      6: dnull[ch] <= 1'b1;
      7: q_trig[ch] <= 1'b1;
      8: q_serv[ch] <= 1'b1;
      default: q_null[ch] <= 1'b1;
    endcase
  endtask : arm
  task automatic tick;
    @(posedge i_sys_clk);
    {man, chn, hw, s_man, s_chn, s_hw, dnull} <= '0;
    {q_trig, q_serv, q_null, i_wr} <= '0;
  endtask : tick
  task automatic hit(int k, int ch);
    @(posedge i_sys_clk);
    arm(k, ch);
    tick();
  endtask : hit
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge i_sys_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    tick();
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rchk(string what, logic [3:0] a, logic [31:0] exp);
    @(posedge i_sys_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 check(what, o_rdata, exp);
  endtask : rchk
  // stall guard: the sequence needs about 120 cycles
  initial begin
    #50000;
    error_cnt++;
    tally_and_finish();
  end
  // main sequence; other error sources held quiet until the held-error check
  initial begin
    {i_resetn, i_wr, i_rd, i_other_err, i_addr, i_wdata} <= '0;
    {man, chn, hw, s_man, s_chn, s_hw, dnull} <= '0;
    {q_trig, q_serv, q_null} <= '0;
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rchk("low", DMT_FLAGS_LOW, 32'h0000_0000);
    rchk("high", DMT_FLAGS_HIGH, 32'h0000_0000);
    rchk("clr", DMT_CLEAR_LOW, 32'h0000_0000);
    wr(DMT_FLAGS_LOW, 32'hFFFF_FFFF);
    rchk("low ro", DMT_FLAGS_LOW, 32'h0000_0000);
    hit(2, 5);
    hit(2, 5);
    rchk("low miss", DMT_FLAGS_LOW, 32'h0000_0020);
    check("pulse", 32'(pulses), 32'h0000_0001);
    check("level", 32'(o_any_err), 32'h0000_0001);
    hit(0, 40);
    hit(1, 40);
    hit(2, 40);
    rchk("srcs", DMT_FLAGS_HIGH, 32'h0000_0000);
    hit(4, 40);
    hit(1, 40);
    rchk("served", DMT_FLAGS_HIGH, 32'h0000_0000);
    hit(0, 40);
    hit(6, 63);
    rchk("high", DMT_FLAGS_HIGH, 32'h8000_0100);
    wr(DMT_CLEAR_HIGH, 32'h0000_0000);
    rchk("hold", DMT_FLAGS_HIGH, 32'h8000_0100);
    wr(DMT_CLEAR_HIGH, 32'h0000_0100);
    rchk("w1c", DMT_FLAGS_HIGH, 32'h8000_0000);
    hit(7, 2);
    hit(7, 2);
    hit(9, 0);
    rchk("quick", DMT_QUICK_FLAGS, 32'h0000_0005);
    check("no repeat", 32'(pulses), 32'h0000_0001);
    wr(DMT_CLEAR_LOW, 32'hFFFF_FFFF);
    wr(DMT_CLEAR_HIGH, 32'hFFFF_FFFF);
    wr(DMT_QUICK_CLEAR, 32'hFFFF_FFFF);
    rchk("q clr", DMT_QUICK_FLAGS, 32'h0000_0000);
    hit(7, 2);
    rchk("q again", DMT_QUICK_FLAGS, 32'h0000_0004);
    check("pulse 2", 32'(pulses), 32'h0000_0002);
    wr(DMT_QUICK_CLEAR, 32'h0000_0004);
    @(posedge i_sys_clk);
    arm(7, 2);
    {i_wr, i_addr, i_wdata} <= {1'b1, DMT_QUICK_CLEAR, 32'h0000_0004};
    tick();
    rchk("set wins", DMT_QUICK_FLAGS, 32'h0000_0004);
    // dma null against a clear of the same bit, then a write to the flags
    @(posedge i_sys_clk);
    arm(6, 0);
    {i_wr, i_addr, i_wdata} <= {1'b1, DMT_CLEAR_LOW, 32'h0000_0001};
    tick();
    rchk("dma set wins", DMT_FLAGS_LOW, 32'h0000_0001);
    wr(DMT_FLAGS_LOW, 32'hFFFF_FFFF);
    rchk("ro held", DMT_FLAGS_LOW, 32'h0000_0001);
    wr(DMT_CLEAR_LOW, 32'h0000_0001);
    wr(DMT_QUICK_CLEAR, 32'h0000_0004);
    // another error register stays flagged, so a new miss gives no pulse
    i_other_err <= 1'b1;
    hit(6, 1);
    rchk("other held", DMT_FLAGS_LOW, 32'h0000_0002);
    check("no pulse", 32'(pulses), 32'h0000_0003);
    // a serviced trigger frees its channel; service beside a trigger re-arms
    hit(7, 1);
    hit(8, 1);
    hit(7, 1);
    @(posedge i_sys_clk);
    arm(7, 1);
    arm(8, 1);
    tick();
    rchk("q served", DMT_QUICK_FLAGS, 32'h0000_0000);
    hit(0, 33);
    hit(3, 33);
    hit(0, 33);
    hit(2, 33);
    hit(5, 33);
    hit(2, 33);
    rchk("man hw served", DMT_FLAGS_HIGH, 32'h0000_0000);
    rchk("unmapped", 4'hF, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : tb_top
